// *** hw/jmf_multiframe.sv ***
/*
  multiframe size selection, local multiframe counter and pre-emphasis
  boost selection for one serial lane of the link transmitter.
  assumes a frame-rate enable pulse, sysref and sync rising-edge events as
  single-cycle pulses synchronous to clk, and a serial bit stream sampled
  once per bitValid.
*/
// How it works
// [RL1] multiframe holds at least ceil(17 / frame octets) frames
// [RL2] one local multiframe period spans exactly K frames
// [RL3] two per lane: 3 octets K=6 at 12 bit, 4 octets K=5 otherwise
// [RL4] packing 2, 4 or 8 per lane; 4 gives K=3, 8 gives K=2
// [RL5] transmitted K field equals frames per multiframe minus one
// [RL6] boost current only on a bit differing from the previous bit
// [RL7] boost level picks one of 16 steps, 0.25 mA each
// [RL8] count reset to zero on subclass event unless forced value set
// [RL9] frame counter wraps K-1 to zero, flagging each boundary
`timescale 1ns/1ps
`default_nettype none

module jmf_multiframe
  import jmf_pkg::*;
#(
  parameter int BOOST_W = 4
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // configuration
  input  wire jmf_mode_s     mode,
  input  wire jmf_subclass_e subclass,
  input  wire logic          multiframe_count_force,
  input  wire logic [4:0]    forceCountValue,
  input  wire logic [3:0]    tx_boost_level,
  // timing events
  input  wire logic          frameTick,
  input  wire logic          sysrefEvent,
  input  wire logic          syncRiseEvent,
  // serial stream
  input  wire logic          bitValid,
  input  wire logic          serialBit,
  // results
  output jmf_size_s          sizeInfo,
  output logic [4:0]         lmfcCount,
  output logic               lmfcBoundary,
  output logic               boostActive,
  output logic [3:0]         boostCurrentStep
);

  // ==========================================================================
  // elaboration checks
  // the step path is built for four bits only, so any other width is refused here
  if (BOOST_W != 4) begin : g_boostWidthBad
    $error("boost field must be 4 bits wide");
  end

  // ==========================================================================
  // size selection
  logic [4:0] frameOctetsNext;
  logic [4:0] kFramesNext;
  logic [4:0] frameOctetsReg;
  logic [4:0] kFramesReg;
  logic [4:0] kFieldReg;

  // table lookup; an unsupported packing code falls back to four per lane
  always_comb begin
    case (mode.packing) // [RL1] every entry gives K times F of at least 17 octets
      PACK_2: begin
        frameOctetsNext = (mode.resolution == RES_12) ? F_PACK2_12 : F_PACK2_HI; // [RL3]
        kFramesNext     = (mode.resolution == RES_12) ? K_PACK2_12 : K_PACK2_HI; // [RL3]
      end
      PACK_8: begin
        frameOctetsNext = F_PACK8_BASE + {2'h0, mode.resolution, 1'b0};  // [RL4]
        kFramesNext     = K_PACK8;                                       // [RL4]
      end
      default: begin
        frameOctetsNext = F_PACK4_BASE + {3'h0, mode.resolution};        // [RL4]
        kFramesNext     = K_PACK4;                                       // [RL4]
      end
    endcase
  end

  // registered so the counter and link parameters see a stable K
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frameOctetsReg <= F_PACK4_BASE;
      kFramesReg     <= K_PACK4;
      kFieldReg      <= K_PACK4 - 5'h01;
    end else begin
      frameOctetsReg <= frameOctetsNext;
      kFramesReg     <= kFramesNext;
      kFieldReg      <= kFramesNext - 5'h01; // [RL5]
    end
  end

  assign sizeInfo = '{frameOctets: frameOctetsReg, kFrames: kFramesReg, kField: kFieldReg};

  // ==========================================================================
  // local multiframe counter
  logic       resetEvent;
  logic [4:0] lmfcCountReg;
  logic       lmfcBoundaryReg;

  // subclass 0 has no multiframe clock, so events there leave it alone
  assign resetEvent = ((subclass == SUB_1) && sysrefEvent) ||
                      ((subclass == SUB_2) && syncRiseEvent);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lmfcCountReg    <= COUNT_ZERO;
      lmfcBoundaryReg <= 1'b0;
    end else if (resetEvent) begin
      lmfcCountReg    <= multiframe_count_force ? forceCountValue : COUNT_ZERO; // [RL8]
      lmfcBoundaryReg <= 1'b0;
    end else if (frameTick) begin
      if (lmfcCountReg >= kFramesReg - 5'h01) begin
        lmfcCountReg    <= COUNT_ZERO; // [RL9] [RL2]
        lmfcBoundaryReg <= 1'b1;
      end else begin
        lmfcCountReg    <= lmfcCountReg + 5'h01;
        lmfcBoundaryReg <= 1'b0;
      end
    end else begin
      lmfcBoundaryReg <= 1'b0;
    end
  end

  assign lmfcCount    = lmfcCountReg;
  assign lmfcBoundary = lmfcBoundaryReg;

  // ==========================================================================
  // pre-emphasis on transitions
  logic       prevBitReg;
  logic       boostReg;
  logic [3:0] stepReg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prevBitReg <= 1'b0;
      boostReg   <= 1'b0;
      stepReg    <= BOOST_RESET;
    end else if (bitValid) begin
      prevBitReg <= serialBit;
      boostReg   <= (serialBit != prevBitReg);                    // [RL6]
      stepReg    <= (serialBit != prevBitReg) ? tx_boost_level : BOOST_RESET; // [RL7]
    end
  end

  assign boostActive      = boostReg;
  assign boostCurrentStep = stepReg;

  // ==========================================================================
  // checks
  // the product fits eight bits for every table entry
  property p_kmin;
    @(posedge clk) disable iff (!reset_n)
    ({3'h0, sizeInfo.kFrames} * {3'h0, sizeInfo.frameOctets}) >= 8'(MIN_MF_OCTETS);
  endproperty
  a_kmin: assert property (p_kmin) else $error("multiframe shorter than 17 octets"); // [RL1]

  // field and frame count must never disagree, even across a mode change
  property p_field;
    @(posedge clk) disable iff (!reset_n)
    sizeInfo.kField == sizeInfo.kFrames - 5'h01;
  endproperty
  a_field: assert property (p_field) else $error("K field not frames minus one"); // [RL5]

  property p_pack2;
    @(posedge clk) disable iff (!reset_n)
    (mode.packing == PACK_2 && mode.resolution == RES_12) |=> $past(mode) != mode ||
      (sizeInfo.kFrames == 5'h06 && sizeInfo.frameOctets == 5'h03);
  endproperty
  a_pack2: assert property (p_pack2) else $error("two per lane 12 bit size wrong"); // [RL3]

  property p_pack8;
    @(posedge clk) disable iff (!reset_n)
    (mode.packing == PACK_8) |=> ($past(mode) != mode) || sizeInfo.kFrames == 5'h02;
  endproperty
  a_pack8: assert property (p_pack8) else $error("eight per lane K wrong"); // [RL4]

  sequence s_wrap;
    frameTick && !resetEvent && lmfcCount == sizeInfo.kFrames - 5'h01;
  endsequence
  property p_wrap;
    @(posedge clk) disable iff (!reset_n)
    s_wrap |=> (lmfcCount == 5'h00 && lmfcBoundary);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // [RL9]

  // a boundary pulse may only follow a wrapping tick that no event overrode
  property p_bound;
    @(posedge clk) disable iff (!reset_n)
    lmfcBoundary |-> $past(frameTick) && !$past(resetEvent) && lmfcCount == 5'h00;
  endproperty
  a_bound: assert property (p_bound) else $error("boundary without a wrap"); // [RL9]

  // subclass 0 has no multiframe phase, so events there must not move the count
  property p_sub0;
    @(posedge clk) disable iff (!reset_n)
    (subclass == SUB_0 && !frameTick) |=> $stable(lmfcCount);
  endproperty
  a_sub0: assert property (p_sub0) else $error("count moved in subclass 0"); // [RL8]

  property p_range;
    @(posedge clk) disable iff (!reset_n || multiframe_count_force)
    lmfcCount < sizeInfo.kFrames || $past(resetEvent) || $past(mode) != mode;
  endproperty
  a_range: assert property (p_range) else $error("count beyond K"); // [RL2]

  property p_sysref;
    @(posedge clk) disable iff (!reset_n)
    resetEvent |=> lmfcCount == ($past(multiframe_count_force) ? $past(forceCountValue) : 5'h00);
  endproperty
  a_sysref: assert property (p_sysref) else $error("count not reset on event"); // [RL8]

  property p_boost;
    @(posedge clk) disable iff (!reset_n)
    bitValid |=> boostActive == ($past(serialBit) != $past(prevBitReg));
  endproperty
  a_boost: assert property (p_boost) else $error("boost not tied to transition"); // [RL6]

  property p_step;
    @(posedge clk) disable iff (!reset_n)
    boostCurrentStep != 4'h0 |-> boostActive;
  endproperty
  a_step: assert property (p_step) else $error("boost current on repeated bit"); // [RL7]

endmodule

`default_nettype wire

// *** hw/jmf_pkg.sv ***
/*
  package for the multiframe configuration and timing block: mode encodings,
  frame and multiframe sizes, field widths and boost step figures.
  assumes nothing beyond a SystemVerilog compiler.
*/
package jmf_pkg;

  // ==========================================================================
  // lane packing and resolution encodings
  localparam logic [1:0] PACK_2 = 2'h0;
  localparam logic [1:0] PACK_4 = 2'h1;
  localparam logic [1:0] PACK_8 = 2'h2;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_16 = 2'h2;

  // ==========================================================================
  // sizes
  localparam int          MIN_MF_OCTETS = 17;
  localparam int          KW            = 5;
  localparam int          FW            = 5;
  localparam logic [4:0]  K_PACK2_12    = 5'h06;
  localparam logic [4:0]  K_PACK2_HI    = 5'h05;
  localparam logic [4:0]  K_PACK4       = 5'h03;
  localparam logic [4:0]  K_PACK8       = 5'h02;
  localparam logic [4:0]  F_PACK2_12    = 5'h03;
  localparam logic [4:0]  F_PACK2_HI    = 5'h04;
  localparam logic [4:0]  F_PACK4_BASE  = 5'h06;
  localparam logic [4:0]  F_PACK8_BASE  = 5'h0c;
  localparam logic [4:0]  COUNT_ZERO    = 5'h00;

  // ==========================================================================
  // pre-emphasis: 16 levels, 0.25 mA per step (step in microamps)
  localparam int          BOOST_LEVELS  = 16;
  localparam int          BOOST_STEP_UA = 250;
  localparam logic [3:0]  BOOST_RESET   = 4'h0;

  // ==========================================================================
  // carried groups
  typedef struct packed {
    logic [1:0] packing;
    logic [1:0] resolution;
  } jmf_mode_s;

  typedef struct packed {
    logic [4:0] frameOctets;
    logic [4:0] kFrames;
    logic [4:0] kField;
  } jmf_size_s;

  typedef enum logic [1:0] {
    SUB_0 = 2'h0,
    SUB_1 = 2'h1,
    SUB_2 = 2'h2
  } jmf_subclass_e;

endpackage

// *** test/jmf_sync_rx.sv ***
/*
  partner model: receiver side that raises its sync request at random.
  assumes clk from the bench and a $urandom seeded once by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// sync source
module jmf_sync_rx (
  // clock
  input  wire logic clk,
  // sync rising-edge event towards the transmitter
  output logic      syncRise
);
  logic syncLvl = 1'b0;
  initial syncRise = 1'b0;
  // level toggles now and then; only a low-to-high change is reported
  always @(posedge clk) begin
    #1;
    syncRise = 1'b0;
    if ($urandom % 6 == 0) begin
      syncRise = ~syncLvl;
      syncLvl  = ~syncLvl;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/*
  bench for jmf_multiframe: random modes, events, ticks and bits, a reset in
  mid-run, with a scoreboard queue checked one cycle later.
  assumes jmf_pkg and jmf_sync_rx are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench top
module tb_top;
  import jmf_pkg::*;
  typedef struct {logic [25:0] v; logic [25:0] m; int due;} jmf_note_s;
  logic          clk = 1'b0, reset_n = 1'b0, multiframe_count_force = 1'b0;
  jmf_mode_s     mode = '{PACK_4, RES_12};
  jmf_subclass_e subclass = SUB_0;
  logic [4:0]    forceCountValue = 5'h00;
  logic [3:0]    tx_boost_level = 4'h0, stepX = 4'h0;
  logic          frameTick = 1'b0, sysrefEvent = 1'b0, syncRiseEvent;
  logic          bitValid = 1'b0, serialBit = 1'b0, prevBit = 1'b0, act = 1'b0, ev;
  jmf_size_s     sizeInfo;
  logic [4:0]    lmfcCount;
  logic          lmfcBoundary, boostActive;
  logic [3:0]    boostCurrentStep;
  logic [25:0]   seen;
  jmf_note_s     q[$], n;
  int            cyc = 0, error_cnt = 0, n_compared = 0, c = 0, k = 3, f = 6;
  assign seen = {sizeInfo, lmfcCount, lmfcBoundary, boostActive, boostCurrentStep};
  jmf_multiframe jmf_multiframe_i (.clk(clk), .reset_n(reset_n), .mode(mode),
    .subclass(subclass), .multiframe_count_force(multiframe_count_force),
    .forceCountValue(forceCountValue), .tx_boost_level(tx_boost_level),
    .frameTick(frameTick), .sysrefEvent(sysrefEvent), .syncRiseEvent(syncRiseEvent),
    .bitValid(bitValid), .serialBit(serialBit), .sizeInfo(sizeInfo),
    .lmfcCount(lmfcCount), .lmfcBoundary(lmfcBoundary), .boostActive(boostActive),
    .boostCurrentStep(boostCurrentStep));
  jmf_sync_rx jmf_sync_rx_i (.clk(clk), .syncRise(syncRiseEvent));
  initial forever #5 clk = ~clk;
  // ============================================================
  // reporting
  task automatic check(input string nm, input logic [25:0] e, input logic [25:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    // a note that never fell due means an answer was never looked at
    if (q.size() != 0) error_cnt++;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watcher: notes fall due one edge after they were driven; also a hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
    #2;
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      check("sizeInfo", n.v & 26'h3fff800, seen & 26'h3fff800);
      check("lmfcCount", n.v & 26'h7c0, seen & 26'h7c0);
      if (n.m[5]) check("lmfcBoundary", n.v & 26'h20, seen & 26'h20);
      check("boost", n.v & 26'h1f, seen & 26'h1f);
    end
  end
  // ============================================================
  // driver: one block per mode, opened by a subclass 1 count reset, except block 6, opened by the mid-run reset
  initial begin
    void'($urandom(376));
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int b = 0; b < 12; b++) begin
      for (int i = 0; i < 64; i++) begin
        @(posedge clk);
        #1;
        if (i == 0) begin
          mode = '{2'($urandom % 4), 2'($urandom % 3)};
          // packing code 3 behaves as four per lane
          k = (mode.packing == PACK_2) ? ((mode.resolution == RES_12) ? 6 : 5)
            : (mode.packing == PACK_8) ? 2 : 3;
          f = (mode.packing == PACK_2) ? ((mode.resolution == RES_12) ? 3 : 4)
            : (mode.packing == PACK_8) ? 12 + 2 * mode.resolution : 6 + mode.resolution;
        end
        // two cycles of reset in mid-run check the reset values and the restart
        reset_n = !(b == 6 && i < 2);
        subclass = (i == 0) ? SUB_1 : jmf_subclass_e'($urandom % 3);
        sysrefEvent = (i == 0) || ($urandom % 8 == 0);
        multiframe_count_force = (i > 0) && ($urandom % 2 == 1);
        forceCountValue = 5'($urandom % k);
        frameTick = 1'($urandom % 2);
        bitValid = 1'($urandom % 2);
        serialBit = 1'($urandom % 2);
        tx_boost_level = 4'($urandom);
        #1;
        ev = reset_n && ((subclass == SUB_1 && sysrefEvent) ||
                         (subclass == SUB_2 && syncRiseEvent));
        if (!reset_n) begin
          c = 0;
          prevBit = 1'b0;
          act = 1'b0;
          stepX = 4'h0;
        end else begin
          if (ev) c = multiframe_count_force ? forceCountValue : 0;
          else if (frameTick) c = (c + 1) % k;
          if (bitValid) begin
            act = serialBit != prevBit;
            prevBit = serialBit;
            stepX = act ? tx_boost_level : 4'h0;
          end
        end
        q.push_back('{{reset_n ? 5'(f) : F_PACK4_BASE, reset_n ? 5'(k) : K_PACK4,
          reset_n ? 5'(k - 1) : K_PACK4 - 5'h01, 5'(c),
          reset_n && !ev && frameTick && c == 0, act, stepX},
          {20'hfffff, !ev, 5'h1f}, cyc + 1});
      end
    end
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
